// *** design/tpsc_pkg.sv ***
// Shared constants, layouts and state types of the transmit power and synth calibration registers
package tpsc_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RAMP_STEP_NS  = 40;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_STAGE_NS  = 2000;
  localparam int CAL_STAGE_CYC = (CAL_STAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register offsets on the configuration port
  localparam logic [5:0] ADDR_TX_CFG = 6'h22;
  localparam logic [5:0] ADDR_PUMP   = 6'h23;
  localparam logic [5:0] ADDR_VCO    = 6'h24;

  // ==========================================================================
  // Field positions
  localparam int PA_IDX_LSB   = 0;
  localparam int LO_BIAS_LSB  = 4;
  localparam int PUMP_CUR_LSB = 0;
  localparam int PUMP_EN_LSB  = 4;
  localparam int PUMP_CFG_LSB = 6;
  localparam int VCO_CUR_LSB  = 0;
  localparam int VCO_CORE_BIT = 5;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] PA_IDX_RST   = 3'h0;
  localparam logic [1:0] LO_BIAS_RST  = 2'h1;
  localparam logic [1:0] PUMP_CFG_RST = 2'h2;
  localparam logic [1:0] PUMP_EN_RST  = 2'h2;
  localparam logic [3:0] PUMP_CUR_RST = 4'h9;
  localparam logic [4:0] VCO_CUR_RST  = 5'h0A;
  localparam logic       VCO_CORE_RST = 1'b0;

  // ==========================================================================
  // Register contents
  typedef struct packed {
    logic [1:0] lo_bias;
    logic [2:0] pa_level_index;
  } tpsc_tx_cfg_s;

  typedef struct packed {
    logic [1:0] cal_cfg;
    logic [1:0] stage_en;
    logic [3:0] current;
  } tpsc_pump_s;

  typedef struct packed {
    logic       core_high;
    logic [4:0] current;
  } tpsc_vco_s;

  // Calibration sequence, Gray coded along idle, pump, vco, done
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_PUMP = 2'h1,
    CAL_VCO  = 2'h3,
    CAL_DONE = 2'h2
  } tpsc_cal_e;

endpackage

// *** design/tpsc_pa_ramp.sv ***
// Power table address stepper for burst ramping and on-off keying shaping
`timescale 1ns/1ps
module tpsc_pa_ramp
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       step_i,
  input  wire logic       burst_i,
  input  wire logic       ook_i,
  input  wire logic       symbol_i,
  input  wire logic [2:0] level_i,
  // Table address
  output logic [2:0]      addr_o
);

  logic [2:0] target;
  logic [2:0] next_addr;

  // Keying target selection
  // One keyed at the index, zero keyed at entry zero; plain formats sit at the index
  assign target = !burst_i ? 3'h0 : (!ook_i ? level_i : (symbol_i ? level_i : 3'h0));

  // One entry per step
  // Walking every entry between zero and the index gives both ramps and shaping
  assign next_addr = (addr_o < target) ? addr_o + 3'h1 :
                     (addr_o > target) ? addr_o - 3'h1 : addr_o;

  // Address register, advanced only on the step enable
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      addr_o <= 3'h0;
    else if (step_i)
      addr_o <= next_addr;
  end

  a_ramp_single_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_i && addr_o != target |=> addr_o == $past(next_addr) && addr_o != $past(addr_o))
    else $error("ramp did not step one entry");

  a_ook_zero_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_i && burst_i && ook_i && !symbol_i && addr_o != 3'h0 |=> addr_o == $past(addr_o) - 3'h1)
    else $error("zero symbol did not lower power");

endmodule

// *** design/tpsc_synth_cal.sv ***
// Synthesizer calibration sequencer with optional charge pump stage
`timescale 1ns/1ps
module tpsc_synth_cal
#(
  parameter int STAGE_CYC = tpsc_pkg::CAL_STAGE_CYC
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [1:0] stage_en_i,
  // Measurements
  input  wire logic [3:0] pump_meas_i,
  input  wire logic [4:0] vco_meas_i,
  // Results
  output logic            pump_wr_o,
  output logic [3:0]      pump_val_o,
  output logic            vco_wr_o,
  output logic [4:0]      vco_val_o,
  output logic            busy_o
);

  localparam int CW = $clog2(STAGE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STAGE_CYC - 1);

  tpsc_pkg::tpsc_cal_e state;
  tpsc_pkg::tpsc_cal_e next_state;
  logic [CW-1:0]       cnt;
  logic                stage_end;
  logic                skip_pump;

  // Stage timing and skip decision
  assign stage_end = (cnt == LAST);
  assign skip_pump = (stage_en_i == 2'h0);

  // Sequence transitions
  always_comb
  begin
    next_state = state;
    case (state)
      tpsc_pkg::CAL_IDLE: if (start_i) next_state = skip_pump ? tpsc_pkg::CAL_VCO : tpsc_pkg::CAL_PUMP;
      tpsc_pkg::CAL_PUMP: if (stage_end) next_state = tpsc_pkg::CAL_VCO;
      tpsc_pkg::CAL_VCO:  if (stage_end) next_state = tpsc_pkg::CAL_DONE;
      tpsc_pkg::CAL_DONE: next_state = tpsc_pkg::CAL_IDLE;
      default:            next_state = tpsc_pkg::CAL_IDLE;
    endcase
  end

  // State, stage counter and result strobes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= tpsc_pkg::CAL_IDLE;
      cnt        <= '0;
      pump_wr_o  <= 1'b0;
      vco_wr_o   <= 1'b0;
      pump_val_o <= 4'h0;
      vco_val_o  <= 5'h00;
    end
    else
    begin
      state      <= next_state;
      cnt        <= (next_state != state) ? '0 : cnt + CW'(1);
      pump_wr_o  <= (state == tpsc_pkg::CAL_PUMP) && stage_end;
      vco_wr_o   <= (state == tpsc_pkg::CAL_VCO) && stage_end;
      pump_val_o <= pump_meas_i;
      vco_val_o  <= vco_meas_i;
    end
  end

  assign busy_o = (state != tpsc_pkg::CAL_IDLE);

  a_pump_stage_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state == tpsc_pkg::CAL_IDLE && start_i && skip_pump |=> state == tpsc_pkg::CAL_VCO ##1 !pump_wr_o)
    else $error("pump stage ran while disabled");

  c_cal_skip: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state == tpsc_pkg::CAL_IDLE && start_i && skip_pump);
  c_cal_full: cover property (@(posedge clk_i) disable iff (!rst_n_i) pump_wr_o);

endmodule

// *** design/tpsc_tx_synth_regs.sv ***
// Transmit front end and synthesizer calibration register bank with power stepping
// ===========================================================================
// What this block does
// - Three-bit power index, reset zero, selects entry
// - Keying uses index for one, zero otherwise
// - Step entries zero to index for ramps
// - Buffer bias field bits 5:4, reset one
// - Pump enable zero skips pump calibration stage
// - Pump current result bits 3:0, reset nine
// - Host-restored calibration values are used directly
// - VCO current result, reset ten, host overrides
// - Bit 5 selects high or low core
`timescale 1ns/1ps
module tpsc_tx_synth_regs
#(
  parameter int RAMP_STEP_CYC = tpsc_pkg::RAMP_STEP_CYC,
  parameter int CAL_STAGE_CYC = tpsc_pkg::CAL_STAGE_CYC
)
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Configuration port
  input  wire logic       cfg_we_i,
  input  wire logic       cfg_re_i,
  input  wire logic [5:0] cfg_addr_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic [7:0]      cfg_rdata_o,
  // Transmit modem
  input  wire logic       burst_i,
  input  wire logic       ook_mode_i,
  input  wire logic       symbol_i,
  output logic [2:0]      pa_table_addr_o,
  output logic [1:0]      pa_lo_bias_o,
  // Synthesizer
  input  wire logic       cal_start_i,
  input  wire logic [3:0] pump_meas_i,
  input  wire logic [4:0] vco_meas_i,
  output logic [3:0]      pump_current_o,
  output logic [1:0]      pump_cal_cfg_o,
  output logic [4:0]      vco_current_o,
  output logic            vco_core_high_o,
  output logic            cal_busy_o
);

  // ==========================================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  // Two stages so that release never lands close to a clock edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // Register storage and decode
  tpsc_pkg::tpsc_tx_cfg_s tx_cfg;
  tpsc_pkg::tpsc_pump_s   pump;
  tpsc_pkg::tpsc_vco_s    vco;
  logic                   wr_tx;
  logic                   wr_pump;
  logic                   wr_vco;
  logic                   cal_pump_wr;
  logic                   cal_vco_wr;
  logic [3:0]             cal_pump_val;
  logic [4:0]             cal_vco_val;
  logic                   cal_busy;
  logic [7:0]             next_rdata;

  // Write strobes per register
  assign wr_tx   = cfg_we_i && (cfg_addr_i == tpsc_pkg::ADDR_TX_CFG);
  assign wr_pump = cfg_we_i && (cfg_addr_i == tpsc_pkg::ADDR_PUMP);
  assign wr_vco  = cfg_we_i && (cfg_addr_i == tpsc_pkg::ADDR_VCO);

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_cfg.pa_level_index <= tpsc_pkg::PA_IDX_RST;
      tx_cfg.lo_bias        <= tpsc_pkg::LO_BIAS_RST;
    end
    else if (wr_tx)
    begin
      tx_cfg.pa_level_index <= cfg_wdata_i[tpsc_pkg::PA_IDX_LSB +: 3];
      tx_cfg.lo_bias        <= cfg_wdata_i[tpsc_pkg::LO_BIAS_LSB +: 2];
    end
  end

  // Host restore wins the same cycle
  // A host write is an explicit restore, so it is kept over a late result
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pump.cal_cfg  <= tpsc_pkg::PUMP_CFG_RST;
      pump.stage_en <= tpsc_pkg::PUMP_EN_RST;
      pump.current  <= tpsc_pkg::PUMP_CUR_RST;
    end
    else if (wr_pump)
    begin
      pump.cal_cfg  <= cfg_wdata_i[tpsc_pkg::PUMP_CFG_LSB +: 2];
      pump.stage_en <= cfg_wdata_i[tpsc_pkg::PUMP_EN_LSB +: 2];
      pump.current  <= cfg_wdata_i[tpsc_pkg::PUMP_CUR_LSB +: 4];
    end
    else if (cal_pump_wr)
      pump.current <= cal_pump_val;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vco.core_high <= tpsc_pkg::VCO_CORE_RST;
      vco.current   <= tpsc_pkg::VCO_CUR_RST;
    end
    else if (wr_vco)
    begin
      vco.core_high <= cfg_wdata_i[tpsc_pkg::VCO_CORE_BIT];
      vco.current   <= cfg_wdata_i[tpsc_pkg::VCO_CUR_LSB +: 5];
    end
    else if (cal_vco_wr)
      vco.current <= cal_vco_val;
  end

  // ==========================================================================
  // Read path
  // Unused bits read zero
  // Unmapped offsets answer zero rather than holding stale data
  assign next_rdata = (cfg_addr_i == tpsc_pkg::ADDR_TX_CFG) ?
                        {2'h0, tx_cfg.lo_bias, 1'b0, tx_cfg.pa_level_index} :
                      (cfg_addr_i == tpsc_pkg::ADDR_PUMP) ? pump :
                      (cfg_addr_i == tpsc_pkg::ADDR_VCO) ? {2'h0, vco} : 8'h00;

  // Read data register, loaded on each read strobe
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cfg_rdata_o <= 8'h00;
    else if (cfg_re_i)
      cfg_rdata_o <= next_rdata;
  end

  // ==========================================================================
  // Power stepping
  localparam int SW = $clog2(RAMP_STEP_CYC + 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(RAMP_STEP_CYC - 1);
  logic [SW-1:0] step_cnt;
  logic          step;

  // Step enable divider; the ramp rate is fixed, not programmable
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_cnt <= '0;
      step     <= 1'b0;
    end
    else
    begin
      step_cnt <= (step_cnt == STEP_LAST) ? '0 : step_cnt + SW'(1);
      step     <= (step_cnt == STEP_LAST);
    end
  end

  tpsc_pa_ramp u_ramp
  (
    .clk_i    (sys_clk_i),
    .rst_n_i  (rst_n),
    .step_i   (step),
    .burst_i  (burst_i),
    .ook_i    (ook_mode_i),
    .symbol_i (symbol_i),
    .level_i  (tx_cfg.pa_level_index),
    .addr_o   (pa_table_addr_o)
  );

  // ==========================================================================
  // Calibration
  // Stage enable steers the sequencer
  // Configuration field feeds the synthesizer as written
  tpsc_synth_cal #(.STAGE_CYC(CAL_STAGE_CYC)) u_cal
  (
    .clk_i       (sys_clk_i),
    .rst_n_i     (rst_n),
    .start_i     (cal_start_i),
    .stage_en_i  (pump.stage_en),
    .pump_meas_i (pump_meas_i),
    .vco_meas_i  (vco_meas_i),
    .pump_wr_o   (cal_pump_wr),
    .pump_val_o  (cal_pump_val),
    .vco_wr_o    (cal_vco_wr),
    .vco_val_o   (cal_vco_val),
    .busy_o      (cal_busy)
  );

  // Busy flag registered so the port comes from a flip-flop
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cal_busy_o <= 1'b0;
    else
      cal_busy_o <= cal_busy;
  end

  // Outputs come straight from the stored values
  assign pa_lo_bias_o    = tx_cfg.lo_bias;
  assign pump_current_o  = pump.current;
  assign pump_cal_cfg_o  = pump.cal_cfg;
  assign vco_current_o   = vco.current;
  assign vco_core_high_o = vco.core_high;

  // ==========================================================================
  // Assertions
  // Index write reaches ramp target
  a_index_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    wr_tx |=> tx_cfg.pa_level_index == $past(cfg_wdata_i[2:0]))
    else $error("power index not stored");

  // Burst ramps up to the index
  a_ramp_reaches: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    burst_i && !ook_mode_i && !wr_tx ##1 (burst_i && !ook_mode_i && !wr_tx) [*7]
    |-> ##[0:80] pa_table_addr_o == tx_cfg.pa_level_index)
    else $error("ramp did not reach the index");

  // Bias write is seen on the port
  a_bias_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    wr_tx |=> pa_lo_bias_o == $past(cfg_wdata_i[5:4]))
    else $error("bias field not driven");

  // Calibrated current lands in the register
  a_pump_result: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    cal_pump_wr && !wr_pump |=> pump_current_o == $past(cal_pump_val))
    else $error("pump result lost");

  a_restore_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    wr_pump && cal_pump_wr |=> pump_current_o == $past(cfg_wdata_i[3:0]))
    else $error("restored pump value not used");

  // VCO override used by the synthesizer
  a_vco_override: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    wr_vco |=> vco_current_o == $past(cfg_wdata_i[4:0]) && vco_core_high_o == $past(cfg_wdata_i[5]))
    else $error("vco override not used");

  a_core_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    !wr_vco |=> vco_core_high_o == $past(vco_core_high_o))
    else $error("core select changed without write");

  a_unused_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    cfg_re_i && cfg_addr_i != tpsc_pkg::ADDR_PUMP |=> cfg_rdata_o[7:6] == 2'h0)
    else $error("unused bits read nonzero");

  // Calibrated VCO current lands in the register
  a_vco_result: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    cal_vco_wr && !wr_vco |=> vco_current_o == $past(cal_vco_val))
    else $error("vco result lost");

  // Configuration field moves only on a write
  a_cal_cfg_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    !wr_pump |=> pump_cal_cfg_o == $past(pump_cal_cfg_o))
    else $error("calibration configuration changed without write");

  // Gap bit of the transmit register reads zero
  a_tx_gap_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    cfg_re_i && cfg_addr_i == tpsc_pkg::ADDR_TX_CFG |=> cfg_rdata_o[3] == 1'b0)
    else $error("transmit gap bit read nonzero");

  // Idle power stays at entry zero
  // Catches a stray step that would key the amplifier between bursts
  a_idle_entry_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    !burst_i && pa_table_addr_o == 3'h0 |=> pa_table_addr_o == 3'h0)
    else $error("table address left zero while idle");

  c_full_ramp: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
    burst_i && pa_table_addr_o == 3'h7);
  c_ook_burst: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
    burst_i && ook_mode_i && !symbol_i && pa_table_addr_o != 3'h0);
  c_restore: cover property (@(posedge sys_clk_i) disable iff (!rst_n) wr_vco && cal_busy);

endmodule

// *** bench/tpsc_host_model.sv ***
// Host side model driving the register port of the calibration register bank
`timescale 1ns/1ps
module tpsc_host_model
(
  // Clock
  input  wire logic       clk_i,
  // Register port
  input  wire logic [7:0] cfg_rdata_i,
  output logic            cfg_we_o,
  output logic            cfg_re_o,
  output logic [5:0]      cfg_addr_o,
  output logic [7:0]      cfg_wdata_o
);
  // ==========================================================================
  // Idle levels, strobes low from time zero
  initial
  begin
    cfg_we_o    = 1'b0;
    cfg_re_o    = 1'b0;
    cfg_addr_o  = 6'h00;
    cfg_wdata_o = 8'h00;
  end

  // Drive at the falling edge, hold through the taking edge, then scramble the released lines
  // host loads values
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    cfg_addr_o  = addr;
    cfg_wdata_o = data;
    cfg_we_o    = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    cfg_we_o    = 1'b0;
    cfg_addr_o  = ~addr;
    cfg_wdata_o = ~data;
  endtask

  // Read data is registered, so it is sampled on the second falling edge after the taking edge
  task automatic rd(input logic [5:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    cfg_addr_o = addr;
    cfg_re_o   = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    cfg_re_o   = 1'b0;
    cfg_addr_o = ~addr;
    @(posedge clk_i);
    @(negedge clk_i);
    data = cfg_rdata_i;
  endtask
endmodule

// *** bench/tb_tpsc_tx_synth_regs.sv ***
// Self-checking bench for the transmit power and synth calibration register bank
`timescale 1ns/1ps
module tb_tpsc_tx_synth_regs;
  // Short counts keep the run brief; stage kept long enough to tell skip from full
  localparam int RAMP = 2;
  localparam int STG  = 8;

  logic       sys_clk_i;
  logic       rst_n_i;
  logic       cfg_we_i;
  logic       cfg_re_i;
  logic [5:0] cfg_addr_i;
  logic [7:0] cfg_wdata_i;
  logic [7:0] cfg_rdata_o;
  logic       burst_i;
  logic       ook_mode_i;
  logic       symbol_i;
  logic [2:0] pa_table_addr_o;
  logic [1:0] pa_lo_bias_o;
  logic       cal_start_i;
  logic [3:0] pump_meas_i;
  logic [4:0] vco_meas_i;
  logic [3:0] pump_current_o;
  logic [1:0] pump_cal_cfg_o;
  logic [4:0] vco_current_o;
  logic       vco_core_high_o;
  logic       cal_busy_o;
  int         err_count;
  int         checks_done;
  logic [7:0] rv;

  tpsc_tx_synth_regs #(.RAMP_STEP_CYC(RAMP), .CAL_STAGE_CYC(STG)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i), .cfg_re_i(cfg_re_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .burst_i(burst_i), .ook_mode_i(ook_mode_i), .symbol_i(symbol_i),
    .pa_table_addr_o(pa_table_addr_o), .pa_lo_bias_o(pa_lo_bias_o), .cal_start_i(cal_start_i),
    .pump_meas_i(pump_meas_i), .vco_meas_i(vco_meas_i), .pump_current_o(pump_current_o),
    .pump_cal_cfg_o(pump_cal_cfg_o), .vco_current_o(vco_current_o),
    .vco_core_high_o(vco_core_high_o), .cal_busy_o(cal_busy_o));

  tpsc_host_model host_u (
    .clk_i(sys_clk_i), .cfg_rdata_i(cfg_rdata_o), .cfg_we_o(cfg_we_i), .cfg_re_o(cfg_re_i),
    .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i));

  // ==========================================================================
  // Clock and watchdog; the limit is far above the few hundred cycles the tests need
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    #250000;
    err_count++;
    give_verdict();
  end

  // ==========================================================================
  // Checking and closing
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Wait, bounded, until the table address reaches a value
  task automatic ramp_to(input logic [2:0] exp);
    for (int i = 0; i < 60 && pa_table_addr_o !== exp; i++)
      @(negedge sys_clk_i);
    check("table addr", {5'h00, pa_table_addr_o}, {5'h00, exp});
  endtask

  // The first move after a target change must be a single entry
  task automatic first_step(input logic [2:0] exp);
    logic [2:0] was;
    was = pa_table_addr_o;
    for (int i = 0; i < 20 && pa_table_addr_o === was; i++)
      @(negedge sys_clk_i);
    check("first step", {5'h00, pa_table_addr_o}, {5'h00, exp});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    host_u.rd(tpsc_pkg::ADDR_TX_CFG, rv);
    check("tx cfg reset", rv, 8'h10);
    check("bias reset", {6'h00, pa_lo_bias_o}, 8'h01);
    host_u.rd(tpsc_pkg::ADDR_PUMP, rv);
    check("pump reset", rv, 8'hA9);
    host_u.rd(tpsc_pkg::ADDR_VCO, rv);
    check("vco reset", rv, 8'h0A);
    check("core reset", {7'h00, vco_core_high_o}, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_masks();
    host_u.wr(tpsc_pkg::ADDR_TX_CFG, 8'hFF);
    host_u.wr(tpsc_pkg::ADDR_PUMP, 8'hFF);
    host_u.wr(tpsc_pkg::ADDR_VCO, 8'hFF);
    host_u.wr(6'h25, 8'hFF);
    host_u.rd(tpsc_pkg::ADDR_TX_CFG, rv);
    check("tx cfg unused", rv, 8'h37);
    host_u.rd(tpsc_pkg::ADDR_PUMP, rv);
    check("pump all", rv, 8'hFF);
    host_u.rd(tpsc_pkg::ADDR_VCO, rv);
    check("vco unused", rv, 8'h3F);
    check("core high", {7'h00, vco_core_high_o}, 8'h01);
    check("vco override", {3'h0, vco_current_o}, 8'h1F);
    host_u.rd(6'h25, rv);
    check("unmapped", rv, 8'h00);
    host_u.wr(tpsc_pkg::ADDR_VCO, 8'h0B);
    check("core low", {7'h00, vco_core_high_o}, 8'h00);
    $display("test_masks done");
  endtask

  task automatic test_ramp();
    host_u.wr(tpsc_pkg::ADDR_TX_CFG, 8'h23);
    check("bias out", {6'h00, pa_lo_bias_o}, 8'h02);
    @(negedge sys_clk_i);
    burst_i = 1'b1;
    first_step(3'h1);
    ramp_to(3'h3);
    @(negedge sys_clk_i);
    burst_i = 1'b0;
    first_step(3'h2);
    ramp_to(3'h0);
    $display("test_ramp done");
  endtask

  task automatic test_keying();
    host_u.wr(tpsc_pkg::ADDR_TX_CFG, 8'h17);
    @(negedge sys_clk_i);
    ook_mode_i = 1'b1;
    symbol_i   = 1'b1;
    burst_i    = 1'b1;
    ramp_to(3'h7);
    check("one symbol", {5'h00, pa_table_addr_o}, 8'h07);
    symbol_i = 1'b0;
    first_step(3'h6);
    ramp_to(3'h0);
    check("zero symbol", {5'h00, pa_table_addr_o}, 8'h00);
    burst_i    = 1'b0;
    ook_mode_i = 1'b0;
    $display("test_keying done");
  endtask

  // Run one calibration and return how many cycles busy stood high
  task automatic run_cal(output int cnt);
    @(negedge sys_clk_i);
    cal_start_i = 1'b1;
    @(negedge sys_clk_i);
    cal_start_i = 1'b0;
    cnt = 0;
    for (int i = 0; i < 4 && cal_busy_o !== 1'b1; i++)
      @(negedge sys_clk_i);
    while (cal_busy_o === 1'b1 && cnt < 200)
    begin
      cnt++;
      @(negedge sys_clk_i);
    end
  endtask

  task automatic test_cal();
    int n;
    host_u.wr(tpsc_pkg::ADDR_PUMP, 8'hA9);
    pump_meas_i = 4'h5;
    vco_meas_i  = 5'h15;
    run_cal(n);
    check("pump result", {4'h0, pump_current_o}, 8'h05);
    check("vco result", {3'h0, vco_current_o}, 8'h15);
    check("full length", {7'h00, n >= 2 * STG}, 8'h01);
    host_u.wr(tpsc_pkg::ADDR_PUMP, 8'h83);
    pump_meas_i = 4'hC;
    vco_meas_i  = 5'h07;
    run_cal(n);
    check("pump skipped", {4'h0, pump_current_o}, 8'h03);
    check("vco only", {3'h0, vco_current_o}, 8'h07);
    check("short length", {7'h00, n <= STG + 3}, 8'h01);
    $display("test_cal done");
  endtask

  task automatic test_restore();
    // saved results written back in place of calibrating
    host_u.wr(tpsc_pkg::ADDR_PUMP, 8'hA5);
    host_u.wr(tpsc_pkg::ADDR_VCO, 8'h2C);
    check("pump restored", {4'h0, pump_current_o}, 8'h05);
    check("cfg restored", {6'h00, pump_cal_cfg_o}, 8'h02);
    check("vco restored", {3'h0, vco_current_o}, 8'h0C);
    host_u.rd(tpsc_pkg::ADDR_VCO, rv);
    check("vco readback", rv, 8'h2C);
    // Restore lands on the very edge of a pump result
    pump_meas_i = 4'hE;
    vco_meas_i  = 5'h11;
    @(negedge sys_clk_i);
    cal_start_i = 1'b1;
    @(negedge sys_clk_i);
    cal_start_i = 1'b0;
    repeat (STG - 1) @(negedge sys_clk_i);
    host_u.wr(tpsc_pkg::ADDR_PUMP, 8'hA6);
    host_u.wr(tpsc_pkg::ADDR_VCO, 8'h01);
    for (int i = 0; i < 4 * STG && cal_busy_o !== 1'b0; i++)
      @(negedge sys_clk_i);
    check("race restore", {4'h0, pump_current_o}, 8'h06);
    check("vco after race", {3'h0, vco_current_o}, 8'h11);
    $display("test_restore done");
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    err_count   = 0;
    checks_done = 0;
    rst_n_i     = 1'b0;
    burst_i     = 1'b0;
    ook_mode_i  = 1'b0;
    symbol_i    = 1'b0;
    cal_start_i = 1'b0;
    pump_meas_i = 4'h0;
    vco_meas_i  = 5'h00;
    repeat (8) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    test_reset();
    test_masks();
    test_ramp();
    test_keying();
    test_cal();
    test_restore();
    // Second reset in mid-run must bring every register back
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    test_reset();
    give_verdict();
  end
endmodule
